// >>> bpl_params.svh
// Functional notes
// - Every power-up starts in application output mode, never programming mode.
// - Host modulates telegrams onto the output pin; device decodes them there.
// - Device replies by modulating its own output on the same pin, half-duplex.
// - A zero bit keeps the line level constant for the whole bit.
// - A one bit adds a level change at half the bit time.
// - The line toggles at every bit boundary; receivers recover timing from it.
// - Replies carry memory contents, error codes and angle values back to the host.
// - In programming mode host write telegrams change register settings until the latch is set.
// - Each write and store returns an acknowledge or an error code for the host to check.
// - Device reports the latch state when read; host confirms the lock.
// - Memory reads are still served after the latch is set.
`ifndef BPL_PARAMS_SVH
`define BPL_PARAMS_SVH

`define BPL_CLK_NS      100
`define BPL_BIT_MIN_NS  10000
`define BPL_BIT_MAX_NS  1100000
`define BPL_SYNC_NS     2000000
`define BPL_BIT_MIN_CYC ((`BPL_BIT_MIN_NS + `BPL_CLK_NS - 1) / `BPL_CLK_NS)
`define BPL_BIT_MAX_CYC (`BPL_BIT_MAX_NS / `BPL_CLK_NS)
`define BPL_SYNC_CYC    ((`BPL_SYNC_NS + `BPL_CLK_NS - 1) / `BPL_CLK_NS)

`define BPL_FRAME_LEN   28
`define BPL_CMD_MSB     27
`define BPL_CMD_W       4
`define BPL_ADDR_MSB    23
`define BPL_ADDR_W      8
`define BPL_DATA_MSB    15
`define BPL_DATA_W      16
`define BPL_LEN_SHORT   6'h04
`define BPL_LEN_ADDR    6'h0C
`define BPL_LEN_FULL    6'h1C

`define BPL_ACK         16'h00A5
`define BPL_ERR_FRAME   16'h00E1
`define BPL_ERR_LEN     16'h00E2
`define BPL_ERR_CMD     16'h00E3
`define BPL_ERR_ADDR    16'h00E4
`define BPL_ERR_LOCKED  16'h00E5

`endif

// >>> bpl_pkg.sv
package bpl_pkg;

  typedef enum logic [1:0] {
    BPL_MD_APP    = 2'h0,
    BPL_MD_LISTEN = 2'h1,
    BPL_MD_TURN   = 2'h3,
    BPL_MD_REPLY  = 2'h2
  } bpl_mode_t;

  typedef enum logic [3:0] {
    BPL_CMD_READ   = 4'h1,
    BPL_CMD_WRITE  = 4'h2,
    BPL_CMD_STORE  = 4'h3,
    BPL_CMD_LOCK   = 4'h4,
    BPL_CMD_STATUS = 4'h5,
    BPL_CMD_ANGLE  = 4'h6
  } bpl_cmd_t;

endpackage

// >>> bpl_rx.sv
`timescale 1ns/1ps
`include "bpl_params.svh"

module bpl_rx #(
  parameter int CNT_W       = 16,
  parameter int BIT_MIN_CYC = `BPL_BIT_MIN_CYC,
  parameter int BIT_MAX_CYC = `BPL_BIT_MAX_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             en_i,
  input  wire logic             line_i,
  output logic                  bit_o,
  output logic                  bit_vld_o,
  output logic                  end_o,
  output logic                  err_o,
  output logic [CNT_W-1:0]      per_o
);

  logic             prev_reg;
  logic             act_reg;
  logic             cal_reg;
  logic             mid_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             edge_s;
  logic             is_mid;
  logic             tmo;

  assign edge_s = line_i ^ prev_reg;
  // Edges well before the period end are mid-bit edges
  assign is_mid = cnt_reg < (per_o - (per_o >> 2));
  assign tmo = act_reg && (cal_reg ? (cnt_reg > CNT_W'(BIT_MAX_CYC))
                                   : ({1'b0, cnt_reg} >= {per_o, 1'b0}));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= line_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_reg   <= 1'b0;
      cal_reg   <= 1'b0;
      mid_reg   <= 1'b0;
      cnt_reg   <= '0;
      per_o     <= '0;
      err_o     <= 1'b0;
      bit_o     <= 1'b0;
      bit_vld_o <= 1'b0;
      end_o     <= 1'b0;
    end else begin
      bit_vld_o <= 1'b0;
      end_o     <= 1'b0;
      if (!en_i) begin
        act_reg <= 1'b0;
      end else if (!act_reg) begin
        if (edge_s) begin
          act_reg <= 1'b1;
          cal_reg <= 1'b1;
          mid_reg <= 1'b0;
          cnt_reg <= '0;
          err_o   <= 1'b0;
        end
      end else if (tmo) begin
        act_reg <= 1'b0;
        end_o   <= 1'b1;
      end else if (edge_s) begin
        if (cal_reg) begin
          // Leading zero bit measures the host bit time
          per_o   <= cnt_reg + 1'b1;
          cal_reg <= 1'b0;
          cnt_reg <= '0;
          err_o   <= (cnt_reg + 1'b1 < CNT_W'(BIT_MIN_CYC)) ||
                     (cnt_reg + 1'b1 > CNT_W'(BIT_MAX_CYC));
        end else if (is_mid) begin
          mid_reg <= 1'b1;
          err_o   <= err_o | mid_reg;
          cnt_reg <= cnt_reg + 1'b1;
        end else begin
          bit_o     <= mid_reg;
          bit_vld_o <= 1'b1;
          mid_reg   <= 1'b0;
          cnt_reg   <= '0;
        end
      end else if (cnt_reg != '1) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  AST_RX_BOUNDARY_BIT : assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && act_reg && !tmo && edge_s && !cal_reg && !is_mid
      |=> bit_vld_o && bit_o == $past(mid_reg))
    else $error("boundary edge gave no bit");

endmodule

// >>> bpl_tx.sv
`timescale 1ns/1ps
`include "bpl_params.svh"

module bpl_tx #(
  parameter int CNT_W = 16
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               start_i,
  input  wire logic [15:0]        data_i,
  input  wire logic [CNT_W-1:0]   per_i,
  output logic                    level_o,
  output logic                    busy_o,
  output logic                    done_o
);

  logic [16:0]      sh_reg;
  logic [4:0]       idx_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             last_s;
  logic             half_s;

  assign last_s = cnt_reg == per_i - 1'b1;
  assign half_s = cnt_reg == (per_i >> 1) - 1'b1;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_reg  <= '0;
      idx_reg <= '0;
      cnt_reg <= '0;
      level_o <= 1'b1;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o) begin
        level_o <= 1'b1;
        if (start_i) begin
          // Leading zero bit lets the host measure our bit time
          busy_o  <= 1'b1;
          level_o <= 1'b0;
          sh_reg  <= {1'b0, data_i};
          idx_reg <= 5'h10;
          cnt_reg <= '0;
        end
      end else if (last_s) begin
        cnt_reg <= '0;
        level_o <= ~level_o;
        sh_reg  <= {sh_reg[15:0], 1'b0};
        if (idx_reg == 5'h00) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          idx_reg <= idx_reg - 1'b1;
        end
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
        if (sh_reg[16] && half_s) begin
          level_o <= ~level_o;
        end
      end
    end
  end

  AST_TX_ZERO_FLAT : assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o && !sh_reg[16] && !last_s |=> level_o == $past(level_o))
    else $error("level moved inside a zero bit");

  AST_TX_ONE_MID : assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o && sh_reg[16] && half_s |=> level_o != $past(level_o))
    else $error("one bit lacks its mid edge");

  AST_TX_EDGE : assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o && last_s |=> level_o != $past(level_o))
    else $error("no level change at bit boundary");

endmodule

// >>> bpl_link.sv
`timescale 1ns/1ps
`include "bpl_params.svh"

module bpl_link #(
  parameter int CNT_W       = 16,
  parameter int BIT_MAX_CYC = `BPL_BIT_MAX_CYC,
  parameter int SYNC_CYC    = `BPL_SYNC_CYC,
  parameter int MEM_DEPTH   = 32
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 line_i,
  input  wire logic                 app_level_i,
  input  wire logic [15:0]          angle_i,
  input  wire logic [7:0]           cfg_addr_i,
  output logic                      line_o,
  output logic                      line_oe_o,
  output logic                      prog_mode_o,
  output logic                      lock_o,
  output logic [15:0]               cfg_data_o
);

  localparam int IDX_W = $clog2(MEM_DEPTH);

  if (SYNC_CYC < 2 || SYNC_CYC >= (1 << CNT_W)) begin : g_chk_sync
    $error("SYNC_CYC does not fit the counter");
  end
  if (BIT_MAX_CYC < `BPL_BIT_MIN_CYC || 2 * BIT_MAX_CYC >= (1 << CNT_W))
  begin : g_chk_bit
    $error("BIT_MAX_CYC does not fit the counter");
  end
  if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || (1 << IDX_W) != MEM_DEPTH)
  begin : g_chk_mem
    $error("MEM_DEPTH must be a power of two up to 256");
  end

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = 9'(a) < 9'(MEM_DEPTH);
  endfunction

  logic                  s1_reg;
  logic                  s2_reg;
  bpl_pkg::bpl_mode_t    mode_reg;
  logic [CNT_W-1:0]      low_cnt_reg;
  logic [CNT_W-1:0]      turn_cnt_reg;
  logic [5:0]            bitcnt_reg;
  logic [27:0]           frame_reg;
  logic [15:0]           reply_reg;
  logic                  lock_reg;
  logic                  sync_seen_reg;
  logic [15:0]           mem [MEM_DEPTH];
  logic [15:0]           nv  [MEM_DEPTH];

  logic                  rx_bit;
  logic                  rx_vld;
  logic                  rx_end;
  logic                  rx_err;
  logic [CNT_W-1:0]      rx_per;
  logic                  tx_level;
  logic                  tx_busy;
  logic                  tx_done;
  logic                  tx_start;

  logic                  sync_hit;
  logic                  exec;
  bpl_pkg::bpl_cmd_t     cmd_s;
  logic [7:0]            addr_s;
  logic [15:0]           data_s;
  logic [IDX_W-1:0]      idx_s;
  logic [5:0]            need_s;
  logic [15:0]           reply_next;
  logic                  wr_en;
  logic                  st_en;
  logic                  lk_en;

  // Pin synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= line_i;
      s2_reg <= s1_reg;
    end
  end

  // Long low pulse on the pin switches to listening
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_reg <= '0;
    end else if (mode_reg != bpl_pkg::BPL_MD_APP || s2_reg) begin
      low_cnt_reg <= '0;
    end else if (!sync_hit) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

  assign sync_hit = mode_reg == bpl_pkg::BPL_MD_APP && !s2_reg &&
                    low_cnt_reg == CNT_W'(SYNC_CYC - 1);

  assign exec     = mode_reg == bpl_pkg::BPL_MD_LISTEN && rx_end &&
                    bitcnt_reg != 6'h00;
  assign tx_start = mode_reg == bpl_pkg::BPL_MD_TURN &&
                    turn_cnt_reg == '0;

  bpl_rx #(
    .CNT_W       (CNT_W),
    .BIT_MIN_CYC (`BPL_BIT_MIN_CYC),
    .BIT_MAX_CYC (BIT_MAX_CYC)
  ) u_rx (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (mode_reg == bpl_pkg::BPL_MD_LISTEN),
    .line_i    (s2_reg),
    .bit_o     (rx_bit),
    .bit_vld_o (rx_vld),
    .end_o     (rx_end),
    .err_o     (rx_err),
    .per_o     (rx_per)
  );

  bpl_tx #(
    .CNT_W (CNT_W)
  ) u_tx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tx_start),
    .data_i  (reply_reg),
    .per_i   (rx_per),
    .level_o (tx_level),
    .busy_o  (tx_busy),
    .done_o  (tx_done)
  );

  // Mode sequencing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= bpl_pkg::BPL_MD_APP;
    end else begin
      case (mode_reg)
        bpl_pkg::BPL_MD_APP: begin
          if (sync_hit) begin
            mode_reg <= bpl_pkg::BPL_MD_LISTEN;
          end
        end
        bpl_pkg::BPL_MD_LISTEN: begin
          if (exec) begin
            mode_reg <= bpl_pkg::BPL_MD_TURN;
          end
        end
        bpl_pkg::BPL_MD_TURN: begin
          if (tx_start) begin
            mode_reg <= bpl_pkg::BPL_MD_REPLY;
          end
        end
        default: begin
          if (tx_done) begin
            mode_reg <= bpl_pkg::BPL_MD_LISTEN;
          end
        end
      endcase
    end
  end

  // One host bit time of turnaround before replying
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      turn_cnt_reg <= '0;
    end else if (exec) begin
      turn_cnt_reg <= rx_per;
    end else if (turn_cnt_reg != '0) begin
      turn_cnt_reg <= turn_cnt_reg - 1'b1;
    end
  end

  // Telegram bit collection, first bit at the top
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bitcnt_reg <= '0;
      frame_reg  <= '0;
    end else if (mode_reg != bpl_pkg::BPL_MD_LISTEN || rx_end) begin
      bitcnt_reg <= '0;
      frame_reg  <= '0;
    end else if (rx_vld && bitcnt_reg != 6'h3F) begin
      bitcnt_reg <= bitcnt_reg + 1'b1;
      if (bitcnt_reg < `BPL_LEN_FULL) begin
        frame_reg[5'(6'(`BPL_FRAME_LEN - 1) - bitcnt_reg)] <= rx_bit;
      end
    end
  end

  // Command decode
  always_comb begin
    cmd_s  = bpl_pkg::bpl_cmd_t'(frame_reg[`BPL_CMD_MSB -: `BPL_CMD_W]);
    addr_s = frame_reg[`BPL_ADDR_MSB -: `BPL_ADDR_W];
    data_s = frame_reg[`BPL_DATA_MSB -: `BPL_DATA_W];
    idx_s  = addr_s[IDX_W-1:0];
    need_s = `BPL_LEN_SHORT;
    reply_next = `BPL_ACK;
    wr_en  = 1'b0;
    st_en  = 1'b0;
    lk_en  = 1'b0;
    case (cmd_s)
      bpl_pkg::BPL_CMD_READ: begin
        need_s = `BPL_LEN_ADDR;
        reply_next = addr_ok(addr_s) ? mem[idx_s] : `BPL_ERR_ADDR;
      end
      bpl_pkg::BPL_CMD_WRITE: begin
        need_s = `BPL_LEN_FULL;
        if (!addr_ok(addr_s)) begin
          reply_next = `BPL_ERR_ADDR;
        end else if (lock_reg) begin
          reply_next = `BPL_ERR_LOCKED;
        end else begin
          wr_en = 1'b1;
        end
      end
      bpl_pkg::BPL_CMD_STORE: begin
        need_s = `BPL_LEN_ADDR;
        if (!addr_ok(addr_s)) begin
          reply_next = `BPL_ERR_ADDR;
        end else if (lock_reg) begin
          reply_next = `BPL_ERR_LOCKED;
        end else begin
          st_en = 1'b1;
        end
      end
      bpl_pkg::BPL_CMD_LOCK: begin
        lk_en = 1'b1;
      end
      bpl_pkg::BPL_CMD_STATUS: begin
        reply_next = {15'h0000, lock_reg};
      end
      bpl_pkg::BPL_CMD_ANGLE: begin
        reply_next = angle_i;
      end
      default: begin
        reply_next = `BPL_ERR_CMD;
      end
    endcase
    if (rx_err) begin
      reply_next = `BPL_ERR_FRAME;
    end else if (bitcnt_reg < need_s) begin
      reply_next = `BPL_ERR_LEN;
    end
    if (rx_err || bitcnt_reg < need_s) begin
      wr_en = 1'b0;
      st_en = 1'b0;
      lk_en = 1'b0;
    end
  end

  // Reply word: read data, status, angle, acknowledge or error code
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reply_reg <= '0;
    end else if (exec) begin
      reply_reg <= reply_next;
    end
  end

  // Write-protect latch, cleared only by power-up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_reg <= 1'b0;
    end else if (exec && lk_en) begin
      lock_reg <= 1'b1;
    end
  end

  // Working registers and stored image
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= '0;
        nv[i]  <= '0;
      end
    end else if (exec) begin
      if (wr_en) begin
        mem[idx_s] <= data_s;
      end
      if (st_en) begin
        nv[idx_s] <= mem[idx_s];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_data_o <= '0;
    end else begin
      cfg_data_o <= addr_ok(cfg_addr_i) ? nv[cfg_addr_i[IDX_W-1:0]] : '0;
    end
  end

  // Pin drive: application output, released, or reply
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_o      <= 1'b1;
      line_oe_o   <= 1'b1;
      prog_mode_o <= 1'b0;
    end else begin
      line_o      <= (mode_reg == bpl_pkg::BPL_MD_REPLY) ? tx_level
                                                         : app_level_i;
      line_oe_o   <= mode_reg == bpl_pkg::BPL_MD_APP ||
                     (mode_reg == bpl_pkg::BPL_MD_REPLY &&
                      (tx_busy || tx_done));
      prog_mode_o <= mode_reg != bpl_pkg::BPL_MD_APP;
    end
  end

  assign lock_o = lock_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_seen_reg <= 1'b0;
    end else if (sync_hit) begin
      sync_seen_reg <= 1'b1;
    end
  end

  sequence s_frame_done;
    mode_reg == bpl_pkg::BPL_MD_LISTEN && rx_end && bitcnt_reg != 6'h00;
  endsequence

  sequence s_write_ok;
    s_frame_done ##0 cmd_s == bpl_pkg::BPL_CMD_WRITE && !rx_err &&
      !lock_reg && addr_ok(addr_s) && bitcnt_reg >= `BPL_LEN_FULL;
  endsequence

  AST_APP_AT_POWERUP : assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reg != bpl_pkg::BPL_MD_APP |-> sync_seen_reg)
    else $error("left application mode without sync");

  AST_SYNC_ENTRY : assert property (@(posedge clk_i) disable iff (rst_i)
    sync_hit |=> mode_reg == bpl_pkg::BPL_MD_LISTEN ##1 !line_oe_o)
    else $error("sync pulse did not enter listening");

  AST_TURN_AFTER_FRAME : assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_frame_done |=> mode_reg == bpl_pkg::BPL_MD_TURN)
    else $error("complete telegram not answered");

  AST_LISTEN_RELEASED : assert property (@(posedge clk_i)
    disable iff (rst_i)
    mode_reg == bpl_pkg::BPL_MD_LISTEN ##1
      mode_reg == bpl_pkg::BPL_MD_LISTEN |-> !line_oe_o)
    else $error("line driven while listening");

  AST_WRITE_ACK : assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_ok |=> reply_reg == `BPL_ACK &&
      mem[$past(idx_s)] == $past(data_s))
    else $error("write not stored or not acknowledged");

  AST_LOCK_BLOCKS_WRITE : assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_frame_done ##0 lock_reg && cmd_s == bpl_pkg::BPL_CMD_WRITE &&
      !rx_err && addr_ok(addr_s) && bitcnt_reg >= `BPL_LEN_FULL
      |=> reply_reg == `BPL_ERR_LOCKED &&
        mem[$past(idx_s)] == $past(mem[idx_s]))
    else $error("write accepted while locked");

  AST_LOCK_STICKY : assert property (@(posedge clk_i) disable iff (rst_i)
    lock_reg |=> lock_reg ##1 lock_o)
    else $error("write-protect latch dropped");

  AST_REPLY_DRIVES : assert property (@(posedge clk_i) disable iff (rst_i)
    tx_start |=> mode_reg == bpl_pkg::BPL_MD_REPLY ##1 line_oe_o)
    else $error("reply not driven on the pin");

endmodule

// >>> bpl_host.sv
`timescale 1ns/1ps

module bpl_host (
  input  wire logic clk_i,
  input  wire logic line_i,
  input  wire logic dev_oe_i,
  output logic      drv_o,
  output logic      lvl_o
);
  int errs;
  bit talk;

  initial begin
    drv_o = 1'b0;
    lvl_o = 1'b1;
    errs  = 0;
    talk  = 1'b0;
  end

  // Device must stay off the pin while the host talks
  always @(posedge clk_i) begin
    if (talk && dev_oe_i) begin
      errs++;
    end
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Long low pulse, overdriving the pin
  task automatic sync(input int n);
    @(negedge clk_i);
    drv_o = 1'b1;
    lvl_o = 1'b0;
    hold(n);
    drv_o = 1'b0;
    lvl_o = 1'b1;
  endtask

  // Calibration zero, then n bits MSB first, then final boundary
  task automatic send(input logic [27:0] w, input int n, input int t);
    @(negedge clk_i);
    talk  = 1'b1;
    drv_o = 1'b1;
    lvl_o = ~lvl_o;
    hold(t);
    for (int i = 0; i < n; i++) begin
      lvl_o = ~lvl_o;
      if (w[27-i]) begin
        hold(t / 2);
        lvl_o = ~lvl_o;
        hold(t - t / 2);
      end else begin
        hold(t);
      end
    end
    lvl_o = ~lvl_o;
    hold(t);
    drv_o = 1'b0;
    lvl_o = 1'b1;
    talk  = 1'b0;
  endtask

  // Decode a reply; each boundary edge resynchronises the sampling
  task automatic recv(input int t, output logic [15:0] w, output bit ok);
    logic a;
    logic b;
    int   k;
    ok = 1'b0;
    w  = 16'h0000;
    k  = 0;
    while (!dev_oe_i && k < 4 * t) begin
      @(negedge clk_i);
      k++;
    end
    b = line_i;
    for (int i = 0; i < 17; i++) begin
      k = 0;
      while (line_i === b && k < t + 4) begin
        @(negedge clk_i);
        k++;
      end
      if (line_i === b) begin
        return;
      end
      if (i < 16) begin
        hold(t / 4);
        a = line_i;
        hold(t / 2);
        b = line_i;
        w[15-i] = a ^ b;
      end
    end
    ok = 1'b1;
  endtask
endmodule

// >>> bpl_link_tb_top.sv
`timescale 1ns/1ps

module bpl_link_tb_top;
  logic        clk;
  logic        rst;
  logic        app_lvl;
  logic [15:0] angle;
  logic [7:0]  cfg_addr;
  logic        dev_lvl;
  logic        dev_oe;
  logic        prog;
  logic        lock;
  logic [15:0] cfg_data;
  logic        host_drv;
  logic        host_lvl;
  wire         pin;
  int          mismatches;
  int          checks_done;
  int          cycles;

  // Host wins over the device; pull-up when nobody drives
  assign pin = host_drv ? host_lvl : (dev_oe ? dev_lvl : 1'b1);

  bpl_link #(.BIT_MAX_CYC(500), .SYNC_CYC(64)) bpl_link_i (
    .clk_i       (clk),
    .rst_i       (rst),
    .line_i      (pin),
    .app_level_i (app_lvl),
    .angle_i     (angle),
    .cfg_addr_i  (cfg_addr),
    .line_o      (dev_lvl),
    .line_oe_o   (dev_oe),
    .prog_mode_o (prog),
    .lock_o      (lock),
    .cfg_data_o  (cfg_data)
  );

  bpl_host bpl_host_i (
    .clk_i    (clk),
    .line_i   (pin),
    .dev_oe_i (dev_oe),
    .drv_o    (host_drv),
    .lvl_o    (host_lvl)
  );

  task end_sim;
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One telegram and its reply; long gap lets stray frames time out
  task xact(input string nm, input logic [27:0] w, input int n,
            input int t, input logic [15:0] e);
    logic [15:0] r;
    bit          ok;
    bpl_host_i.send(w, n, t);
    bpl_host_i.recv(t, r, ok);
    chk({nm, " framing"}, 16'h0001, {15'h0000, ok});
    chk(nm, e, r);
    idle(4);
    chk({nm, " release"}, 16'h0000, {15'h0000, dev_oe});
    idle(600);
  endtask

  task t_reset;
    chk("mode", 16'h0000, {15'h0000, prog});
    chk("app oe", 16'h0001, {15'h0000, dev_oe});
    app_lvl = 1'b0;
    idle(2);
    chk("app level", 16'h0000, {15'h0000, dev_lvl});
  endtask

  task t_sync;
    app_lvl = 1'b1;
    bpl_host_i.sync(72);
    idle(600);
    chk("prog mode", 16'h0001, {15'h0000, prog});
    chk("listen oe", 16'h0000, {15'h0000, dev_oe});
  endtask

  task t_rw;
    xact("write", {4'h2, 8'h1F, 16'hA5C3}, 28, 100, 16'h00A5);
    xact("read slow", {4'h1, 8'h1F, 16'h0000}, 12, 400, 16'hA5C3);
  endtask

  task t_store;
    cfg_addr = 8'h1F;
    idle(2);
    chk("image old", 16'h0000, cfg_data);
    xact("store", {4'h3, 8'h1F, 16'h0000}, 12, 100, 16'h00A5);
    chk("image new", 16'hA5C3, cfg_data);
  endtask

  task t_angle;
    angle = 16'h5A3C;
    xact("angle", {4'h6, 24'h000000}, 4, 100, 16'h5A3C);
  endtask

  task t_lock;
    xact("status 0", {4'h5, 24'h000000}, 4, 100, 16'h0000);
    xact("verify", {4'h1, 8'h1F, 16'h0000}, 12, 100, 16'hA5C3);
    xact("lock", {4'h4, 24'h000000}, 4, 100, 16'h00A5);
    chk("lock", 16'h0001, {15'h0000, lock});
    xact("status 1", {4'h5, 24'h000000}, 4, 100, 16'h0001);
    xact("locked write", {4'h2, 8'h1F, 16'h1234}, 28, 100, 16'h00E5);
    xact("locked read", {4'h1, 8'h1F, 16'h0000}, 12, 100, 16'hA5C3);
  endtask

  task t_errors;
    xact("bad cmd", {4'hF, 24'h000000}, 4, 100, 16'h00E3);
    xact("bad addr", {4'h2, 8'h20, 16'h0000}, 28, 100, 16'h00E4);
    xact("short", {4'h1, 24'h000000}, 4, 100, 16'h00E2);
    xact("bad time", {4'h5, 24'h000000}, 4, 50, 16'h00E1);
    chk("overlap", 16'h0000, bpl_host_i.errs[15:0]);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 90000) begin
      mismatches++;
      end_sim;
    end
  end

  initial begin
    rst         = 1'b1;
    app_lvl     = 1'b1;
    angle       = 16'h0000;
    cfg_addr    = 8'h00;
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    idle(2);
    t_reset;
    t_sync;
    t_rw;
    t_store;
    t_angle;
    t_lock;
    t_errors;
    end_sim;
  end
endmodule
